/* File: rtl/rfm_pkg.sv */
// Constants, register map and state type of the reading filter block
package rfm_pkg;

    // Geometry
    localparam int RFM_NCH = 4;             // Number of sensor inputs
    localparam int RFM_DW = 24;             // Reading width, signed, preferred unit
    localparam int RFM_KW = 16;             // Kelvin reading width, 0.1 K per lsb
    localparam int RFM_FRAC = 8;            // Extra fraction bits in the average
    localparam int RFM_AW = 32;             // Average accumulator width

    // Global register byte offsets
    localparam logic [11:0] RFM_CTRL_OFS = 12'h000;   // Max/min reset strobe
    localparam logic [11:0] RFM_STS_OFS = 12'h004;    // Sticky event status, write 1 to clear
    localparam logic [11:0] RFM_MSK_OFS = 12'h008;    // Interrupt mask
    localparam logic [11:0] RFM_CH_BASE = 12'h040;    // First per-input bank
    localparam logic [11:0] RFM_CH_LAST = 12'h0bc;    // Last byte word of the banks

    // Word index inside a per-input bank (32 byte stride)
    localparam logic [2:0] RFM_R_CFG = 3'h0;    // Enable, points, window, unit
    localparam logic [2:0] RFM_R_LIM = 3'h1;    // Temperature limit
    localparam logic [2:0] RFM_R_FSR = 3'h2;    // Full-scale range
    localparam logic [2:0] RFM_R_FLT = 3'h3;    // Filtered value, read only
    localparam logic [2:0] RFM_R_MAX = 3'h4;    // Highest reading, read only
    localparam logic [2:0] RFM_R_MIN = 3'h5;    // Lowest reading, read only
    localparam logic [2:0] RFM_R_MMV = 3'h6;    // Max/min valid, read only

    // Field positions of the configuration word
    localparam int RFM_CFG_EN = 0;          // Filter enable
    localparam int RFM_CFG_PTS = 8;         // Point count, 7 bits
    localparam int RFM_CFG_WIN = 16;        // Window percent, 4 bits
    localparam int RFM_CFG_UNIT = 24;       // Preferred unit, 2 bits

    // Limits and reset values
    localparam logic [6:0] RFM_PTS_MIN = 7'h02;     // 2 points
    localparam logic [6:0] RFM_PTS_MAX = 7'h40;     // 64 points
    localparam logic [6:0] RFM_PTS_RST = 7'h08;     // 8 points
    localparam logic [3:0] RFM_WIN_MIN = 4'h1;      // 1 percent
    localparam logic [3:0] RFM_WIN_MAX = 4'ha;      // 10 percent
    localparam logic [3:0] RFM_WIN_RST = 4'ha;      // 10 percent
    localparam logic [15:0] RFM_LIM_MAX = 16'h7526; // 2999.0 K in 0.1 K steps
    localparam logic [15:0] RFM_LIM_RST = 16'h0000; // 0 K, check off
    localparam logic [23:0] RFM_FSR_RST = 24'hffffff; // Full-scale range after reset
    localparam logic [31:0] RFM_PCT_SCALE = 32'h00000064; // 100 percent

    // Preferred unit encoding
    typedef enum logic [1:0] {
        RFM_UNIT_K = 2'h0,
        RFM_UNIT_C = 2'h1,
        RFM_UNIT_SENSOR = 2'h2
    } rfm_unit_t;

    // Whole state of the block
    typedef struct packed {
        logic [RFM_NCH-1:0] fen;                    // Filter enables
        logic [RFM_NCH-1:0][6:0] pts;               // Point counts
        logic [RFM_NCH-1:0][3:0] win;               // Window percent
        logic [RFM_NCH-1:0][1:0] unit;              // Preferred units
        logic [RFM_NCH-1:0][RFM_KW-1:0] lim;        // Temperature limits
        logic [RFM_NCH-1:0][RFM_DW-1:0] fsr;        // Full-scale ranges
        logic [RFM_NCH-1:0][RFM_AW-1:0] avg;        // Running averages
        logic [RFM_NCH-1:0] prim;                   // Average holds a value
        logic [RFM_NCH-1:0][RFM_DW-1:0] mx;         // Highest readings
        logic [RFM_NCH-1:0][RFM_DW-1:0] mn;         // Lowest readings
        logic [RFM_NCH-1:0] mmv;                    // Max/min hold a reading
        logic [7:0] sts;                            // Sticky events
        logic [7:0] msk;                            // Interrupt mask
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic out_valid;
        logic [1:0] out_chan;
        logic [RFM_DW-1:0] out_value;
        logic ctl_valid;
        logic [1:0] ctl_chan;
        logic [RFM_DW-1:0] ctl_value;
        logic shutdown;
        logic irq;
    } rfm_state_t;

endpackage

/* File: rtl/rfm_reading_filter.sv */
// Per-input reading filter, max/min tracker and over-temperature shutdown
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - Enabled filter smooths each reported reading except seed and restart readings
// - One filter output per incoming reading
// - Control gets raw; features get filtered
// - One point equals one new reading
// - Points 2 to 64, default 8
// - Time constant set by points and interval
// - Default eight points settle in 45 readings
// - Large single jump restarts the filter
// - Window 1 to 10 percent full scale
// - Any input over limit raises shutdown
// - Per-input limit to 2999 K, 0 off
// - Keep highest and lowest reading per input
// - Max/min capture always runs
// - Max/min cleared on reset, change, request
// - Max/min in preferred unit
module rfm_reading_filter
    import rfm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rd_valid,
    input wire logic [1:0] rd_chan,
    input wire logic [RFM_DW-1:0] rd_value,
    input wire logic [RFM_KW-1:0] rd_kelvin,
    output logic out_valid,
    output logic [1:0] out_chan,
    output logic [RFM_DW-1:0] out_value,
    output logic ctl_valid,
    output logic [1:0] ctl_chan,
    output logic [RFM_DW-1:0] ctl_value,
    output logic [2*RFM_NCH-1:0] unit_sel,
    output logic shutdown,
    output logic irq
);

    rfm_state_t s_q;                        // Registered state
    rfm_state_t s_d;                        // Next state

    logic apb_req;                          // Access phase waiting for its answer
    logic apb_wr;                           // Write completes at this edge
    logic in_bank;                          // Address inside the per-input banks
    logic [11:0] bank_ofs;                  // Offset from the first bank
    logic [1:0] bch;                        // Bank channel
    logic [2:0] breg;                       // Word inside the bank
    logic [7:0] sts_set;                    // Events of this cycle
    logic [7:0] sts_clr;                    // Software clears of this cycle
    logic [6:0] wpts;                       // Clamped point count
    logic [3:0] wwin;                       // Clamped window
    logic [15:0] wlim;                      // Clamped limit
    logic signed [RFM_AW:0] xs;             // Reading with fraction bits
    logic signed [RFM_AW:0] diff;           // Reading minus average
    logic signed [RFM_AW:0] step;           // Difference over points
    logic signed [RFM_DW:0] dev;            // Reading minus filtered value
    logic [RFM_DW:0] dev_abs;               // Magnitude of the jump
    logic [31:0] dev_pct;                   // Jump times 100
    logic [31:0] thr_pct;                   // Full scale times window percent
    logic [RFM_DW-1:0] rep;                 // Value reported for this reading
    logic [RFM_DW-1:0] cur_flt;             // Filtered value of the reading channel

    // Next-state logic: bus slave, configuration, filter, tracker, limits
    always_comb begin
        s_d = s_q;
        xs = '0;
        diff = '0;
        step = '0;
        dev = '0;
        dev_abs = '0;
        dev_pct = '0;
        thr_pct = '0;
        rep = '0;
        cur_flt = '0;
        sts_set = '0;
        sts_clr = '0;
        wpts = RFM_PTS_RST;
        wwin = RFM_WIN_RST;
        wlim = RFM_LIM_RST;
        s_d.out_valid = 1'b0;
        s_d.ctl_valid = 1'b0;

        // Decode of the address
        bank_ofs = paddr - RFM_CH_BASE;
        in_bank = (paddr >= RFM_CH_BASE) && (paddr <= RFM_CH_LAST);
        bch = bank_ofs[6:5];
        breg = bank_ofs[4:2];
        apb_req = psel && penable && !s_q.pready;
        apb_wr = psel && penable && s_q.pready && pwrite && !s_q.pslverr;

        // Answer one cycle into the access phase
        s_d.pready = apb_req;
        if (apb_req) begin
            s_d.prdata = '0;
            s_d.pslverr = 1'b0;
            if (paddr[1:0] != 2'h0) begin
                // Misaligned address
                s_d.pslverr = 1'b1;
            end else if (paddr == RFM_CTRL_OFS) begin
                // Strobe register reads as zero
                s_d.prdata = '0;
            end else if (paddr == RFM_STS_OFS) begin
                s_d.prdata = {24'h000000, s_q.sts};
            end else if (paddr == RFM_MSK_OFS) begin
                s_d.prdata = {24'h000000, s_q.msk};
            end else if (in_bank) begin
                case (breg)
                    RFM_R_CFG: begin
                        s_d.prdata[RFM_CFG_EN] = s_q.fen[bch];
                        s_d.prdata[RFM_CFG_PTS +: 7] = s_q.pts[bch];
                        s_d.prdata[RFM_CFG_WIN +: 4] = s_q.win[bch];
                        s_d.prdata[RFM_CFG_UNIT +: 2] = s_q.unit[bch];
                    end
                    RFM_R_LIM: s_d.prdata = {16'h0000, s_q.lim[bch]};
                    RFM_R_FSR: s_d.prdata = {8'h00, s_q.fsr[bch]};
                    RFM_R_FLT: s_d.prdata = {8'h00, s_q.avg[bch][RFM_FRAC +: RFM_DW]};
                    RFM_R_MAX: s_d.prdata = {8'h00, s_q.mx[bch]};
                    RFM_R_MIN: s_d.prdata = {8'h00, s_q.mn[bch]};
                    RFM_R_MMV: s_d.prdata = {31'h00000000, s_q.mmv[bch]};
                    default: s_d.pslverr = 1'b1;
                endcase
            end else begin
                // Unmapped address
                s_d.pslverr = 1'b1;
            end
        end

        // Writes take effect at the edge that completes the access
        if (apb_wr) begin
            if (paddr == RFM_CTRL_OFS) begin
                if (pwdata[0]) begin
                    s_d.mmv = '0;
                end
            end else if (paddr == RFM_STS_OFS) begin
                sts_clr = pwdata[7:0];
            end else if (paddr == RFM_MSK_OFS) begin
                s_d.msk = pwdata[7:0];
            end else if (in_bank) begin
                // Any change of an input's parameters clears its max/min
                if (breg <= RFM_R_FSR) begin
                    s_d.mmv[bch] = 1'b0;
                end
                case (breg)
                    RFM_R_CFG: begin
                        // Clamp the point count into its legal span
                        wpts = pwdata[RFM_CFG_PTS +: 7];
                        if (wpts < RFM_PTS_MIN) begin
                            wpts = RFM_PTS_MIN;
                        end else if (wpts > RFM_PTS_MAX) begin
                            wpts = RFM_PTS_MAX;
                        end
                        // Clamp the window into its legal span
                        wwin = pwdata[RFM_CFG_WIN +: 4];
                        if (wwin < RFM_WIN_MIN) begin
                            wwin = RFM_WIN_MIN;
                        end else if (wwin > RFM_WIN_MAX) begin
                            wwin = RFM_WIN_MAX;
                        end
                        // A new enable or point count restarts the average
                        if (pwdata[RFM_CFG_EN] != s_q.fen[bch] || wpts != s_q.pts[bch]) begin
                            s_d.prim[bch] = 1'b0;
                        end
                        s_d.fen[bch] = pwdata[RFM_CFG_EN];
                        s_d.pts[bch] = wpts;
                        s_d.win[bch] = wwin;
                        s_d.unit[bch] = pwdata[RFM_CFG_UNIT +: 2];
                    end
                    RFM_R_LIM: begin
                        wlim = pwdata[15:0];
                        if (wlim > RFM_LIM_MAX) begin
                            wlim = RFM_LIM_MAX;
                        end
                        s_d.lim[bch] = wlim;
                    end
                    RFM_R_FSR: s_d.fsr[bch] = pwdata[RFM_DW-1:0];
                    default: s_d.fsr = s_d.fsr;                 // Read-only words ignore writes
                endcase
            end
        end

        // One reading in gives one reported value out
        if (rd_valid) begin
            cur_flt = s_q.avg[rd_chan][RFM_FRAC +: RFM_DW];
            xs = {{(RFM_AW-RFM_DW-RFM_FRAC+1){rd_value[RFM_DW-1]}}, rd_value, 8'h00};
            diff = xs - {s_q.avg[rd_chan][RFM_AW-1], s_q.avg[rd_chan]};
            step = diff / $signed({26'h0000000, s_q.pts[rd_chan]});
            dev = $signed({rd_value[RFM_DW-1], rd_value}) - $signed({cur_flt[RFM_DW-1], cur_flt});
            dev_abs = dev[RFM_DW] ? -dev : dev;
            dev_pct = 32'(dev_abs) * RFM_PCT_SCALE;
            thr_pct = 32'(s_q.fsr[rd_chan]) * 32'(s_q.win[rd_chan]);
            if (!s_d.fen[rd_chan]) begin
                // Filter off: report the raw reading
                s_d.prim[rd_chan] = 1'b0;
                rep = rd_value;
            end else if (!s_d.prim[rd_chan]) begin
                // First reading after enable or reset seeds the average
                s_d.avg[rd_chan] = xs[RFM_AW-1:0];
                s_d.prim[rd_chan] = 1'b1;
                rep = rd_value;
            end else if (dev_pct > thr_pct) begin
                // Deliberate step: restart instead of averaging
                s_d.avg[rd_chan] = xs[RFM_AW-1:0];
                sts_set[4 + rd_chan] = 1'b1;
                rep = rd_value;
            end else begin
                // Exponential running average, time constant per points
                s_d.avg[rd_chan] = s_q.avg[rd_chan] + step[RFM_AW-1:0];
                rep = s_d.avg[rd_chan][RFM_FRAC +: RFM_DW];
            end
            // Reported stream carries the filtered value
            s_d.out_valid = 1'b1;
            s_d.out_chan = rd_chan;
            s_d.out_value = rep;
            // Control loops see the raw value
            s_d.ctl_valid = 1'b1;
            s_d.ctl_chan = rd_chan;
            s_d.ctl_value = rd_value;
            // Max/min tracking on every reading, no enable
            if (!s_d.mmv[rd_chan]) begin
                s_d.mx[rd_chan] = rep;
                s_d.mn[rd_chan] = rep;
                s_d.mmv[rd_chan] = 1'b1;
            end else begin
                if ($signed(rep) > $signed(s_q.mx[rd_chan])) begin
                    s_d.mx[rd_chan] = rep;
                end
                if ($signed(rep) < $signed(s_q.mn[rd_chan])) begin
                    s_d.mn[rd_chan] = rep;
                end
            end
            // Over-temperature check, a zero limit disables it
            if (s_q.lim[rd_chan] != 16'h0000 && rd_kelvin > s_q.lim[rd_chan]) begin
                sts_set[rd_chan] = 1'b1;
            end
        end

        // Sticky status: a new event wins over a clear in the same cycle
        s_d.sts = (s_q.sts & ~sts_clr) | sts_set;
        // Any latched over-limit event raises shutdown; the control outputs keep running
        s_d.shutdown = |s_d.sts[3:0];
        s_d.irq = |(s_d.sts & s_d.msk);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.pts <= {RFM_NCH{RFM_PTS_RST}};
            s_q.win <= {RFM_NCH{RFM_WIN_RST}};
            s_q.lim <= {RFM_NCH{RFM_LIM_RST}};
            s_q.fsr <= {RFM_NCH{RFM_FSR_RST}};
            s_q.unit <= {RFM_NCH{RFM_UNIT_K}};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign out_valid = s_q.out_valid;
    assign out_chan = s_q.out_chan;
    assign out_value = s_q.out_value;
    assign ctl_valid = s_q.ctl_valid;
    assign ctl_chan = s_q.ctl_chan;
    assign ctl_value = s_q.ctl_value;
    assign unit_sel = s_q.unit;
    assign shutdown = s_q.shutdown;
    assign irq = s_q.irq;

endmodule // rfm_reading_filter

/* File: test/rfm_chk.sv */
// Port-level assertions for the reading filter block
`timescale 1ns/1ps
module rfm_chk
    import rfm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rd_valid,
    input wire logic [1:0] rd_chan,
    input wire logic [RFM_DW-1:0] rd_value,
    input wire logic out_valid,
    input wire logic [1:0] out_chan,
    input wire logic [RFM_DW-1:0] out_value,
    input wire logic ctl_valid,
    input wire logic [1:0] ctl_chan,
    input wire logic [RFM_DW-1:0] ctl_value,
    input wire logic shutdown
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completing status write, the only thing allowed to drop shutdown
    wire sts_wr = pready && pwrite && paddr == RFM_STS_OFS;
    // Each reading gives a reported value on the next cycle
    property p_out_next; rd_valid |=> out_valid && out_chan == $past(rd_chan); endproperty
    a_out_next: assert property (p_out_next)
        else $error("reported value missing after a reading");
    // No reported value without a reading
    property p_out_cause; out_valid |-> $past(rd_valid); endproperty
    a_out_cause: assert property (p_out_cause)
        else $error("reported value without a reading");
    // Reported value holds between pulses
    property p_out_hold; !out_valid |-> $stable(out_value) && $stable(out_chan); endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("reported value changed without a pulse");
    // Control loops see the raw reading one cycle later
    property p_ctl_raw;
        rd_valid |=> ctl_valid && ctl_value == $past(rd_value) && ctl_chan == $past(rd_chan);
    endproperty
    a_ctl_raw: assert property (p_ctl_raw)
        else $error("control value is not the raw reading");
    // Shutdown only rises after a reading
    property p_sd_cause; $rose(shutdown) |-> $past(rd_valid); endproperty
    a_sd_cause: assert property (p_sd_cause)
        else $error("shutdown rose without a reading");
    // Shutdown stays latched until status is cleared
    property p_sd_hold; shutdown && !sts_wr && !$past(sts_wr) |=> shutdown; endproperty
    a_sd_hold: assert property (p_sd_hold)
        else $error("shutdown dropped without a status clear");
    // One wait state, then a single-cycle ready
    property p_apb_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("bus answer not in the second access cycle");
    property p_apb_pulse; pready |=> !pready; endproperty
    a_apb_pulse: assert property (p_apb_pulse)
        else $error("ready held longer than one cycle");
    // Unmapped word answers with an error
    property p_bad_addr; pready && paddr == 12'h0fc |-> pslverr; endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("unmapped access without error");
    c_burst: cover property (rd_valid ##1 rd_valid);
    c_trip: cover property ($rose(shutdown));
    c_err: cover property (pready && pslverr);
endmodule // rfm_chk

/* File: test/rfm_front_end.sv */
// Behavioural sensor front end that hands readings to the filter block
`timescale 1ns/1ps
module rfm_front_end
    import rfm_pkg::*;
(
    input wire logic pclk,
    output logic rd_valid,
    output logic [1:0] rd_chan,
    output logic [RFM_DW-1:0] rd_value,
    output logic [RFM_KW-1:0] rd_kelvin
);
    // Quiet lines at time zero
    initial begin
        {rd_valid, rd_chan, rd_value, rd_kelvin} = '0;
    end
    // One reading per call, each a new filter point; calls may stream
    task automatic send(input logic [1:0] c, input logic [RFM_DW-1:0] v,
                        input logic [RFM_KW-1:0] k);
        {rd_valid, rd_chan, rd_value, rd_kelvin} <= {1'b1, c, v, k};
        @(posedge pclk);
    endtask
    // Between frames the data lines carry no stale value
    task automatic idle();
        {rd_valid, rd_chan, rd_value, rd_kelvin} <= {1'b0, ~rd_chan, ~rd_value, ~rd_kelvin};
        @(posedge pclk);
    endtask
endmodule // rfm_front_end

/* File: test/tb.sv */
// Self-checking bench for the reading filter block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
    import rfm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, seed = 32'h0000000f;
    logic pready, pslverr, rd_valid, out_valid, ctl_valid, shutdown, irq;
    logic [1:0] rd_chan, out_chan, ctl_chan;
    logic [RFM_DW-1:0] rd_value, out_value, ctl_value;
    logic [RFM_KW-1:0] rd_kelvin;
    logic [7:0] unit_sel, sts = 8'h00, msk = 8'h00;
    logic [32:0] aq[$], ea;
    logic [50:0] rq[$], er;
    logic [6:0] tp[4] = '{7'h01, 7'h08, 7'h40, 7'h7f};
    int error_cnt = 0, checks = 0, cyc = 0, o;
    int pts[4] = '{8, 8, 8, 8}, win[4] = '{10, 10, 10, 10}, fsr[4] = '{default: 16777215};
    int lim[4], avg[4], mx[4], mn[4];
    bit fen[4], prim[4], mmv[4];
    // Clock at 200 MHz
    always #2.5 pclk = ~pclk;
    rfm_reading_filter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rd_valid(rd_valid), .rd_chan(rd_chan), .rd_value(rd_value),
        .rd_kelvin(rd_kelvin), .out_valid(out_valid), .out_chan(out_chan),
        .out_value(out_value), .ctl_valid(ctl_valid), .ctl_chan(ctl_chan),
        .ctl_value(ctl_value), .unit_sel(unit_sel), .shutdown(shutdown), .irq(irq));
    rfm_front_end fe (.pclk(pclk), .rd_valid(rd_valid), .rd_chan(rd_chan),
        .rd_value(rd_value), .rd_kelvin(rd_kelvin));
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] ba(input int c, input logic [2:0] r);
        return RFM_CH_BASE + 12'(32 * c) + 12'(4 * r);
    endfunction
    // One APB transfer, request held until ready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) error_cnt++;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // Read with the expected error flag and data noted
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        aq.push_back(e);
        apb(1'b0, a, 32'h00000000);
    endtask
    // Shutdown and interrupt lines against the model
    task automatic lines();
        repeat (2) @(posedge pclk);
        `CHK({shutdown, irq}, {|sts[3:0], |(sts & msk)})
    endtask
    // Configure one input and read back its configuration and limit words
    task automatic wcfg(input int c, input logic [6:0] p, input logic [3:0] w,
                        input logic [15:0] l, input int f, input bit en, input logic [1:0] u);
        logic [6:0] pc;
        logic [3:0] wc;
        pc = p < RFM_PTS_MIN ? RFM_PTS_MIN : (p > RFM_PTS_MAX ? RFM_PTS_MAX : p);
        wc = w < RFM_WIN_MIN ? RFM_WIN_MIN : (w > RFM_WIN_MAX ? RFM_WIN_MAX : w);
        if (en != fen[c] || pc != pts[c]) prim[c] = 0;
        fen[c] = en;
        pts[c] = pc;
        win[c] = wc;
        fsr[c] = f;
        lim[c] = l > RFM_LIM_MAX ? RFM_LIM_MAX : l;
        mmv[c] = 0;
        apb(1'b1, ba(c, RFM_R_CFG), {6'h00, u, 4'h0, w, 1'b0, p, 7'h00, en});
        apb(1'b1, ba(c, RFM_R_LIM), {16'h0000, l});
        apb(1'b1, ba(c, RFM_R_FSR), 32'(f));
        rd(ba(c, RFM_R_CFG), {7'h00, u, 4'h0, wc, 1'b0, pc, 7'h00, en});
        rd(ba(c, RFM_R_LIM), {17'h00000, 16'(lim[c])});
        `CHK(unit_sel[2*c +: 2], u)
    endtask
    // Model one reading, note the expected outputs, then send it
    task automatic rdg(input int c, input int v, input int k);
        if (!fen[c]) o = v;
        else if (!prim[c] || (v > avg[c] / 256 ? v - avg[c] / 256 : avg[c] / 256 - v) * 100
                 > fsr[c] * win[c]) begin
            if (prim[c]) sts[4+c] = 1'b1;
            avg[c] = v * 256;
            prim[c] = 1;
            o = v;
        end else begin
            avg[c] = avg[c] + (v * 256 - avg[c]) / pts[c];
            o = avg[c] / 256;
        end
        if (lim[c] != 0 && k > lim[c]) sts[c] = 1'b1;
        if (!mmv[c] || o > mx[c]) mx[c] = o;
        if (!mmv[c] || o < mn[c]) mn[c] = o;
        mmv[c] = 1;
        rq.push_back({2'(c), 24'(o), 1'b1, 24'(v)});
        fe.send(2'(c), 24'(v), 16'(k));
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Scoreboard and run-time limit
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            ea = aq.size() > 0 ? aq.pop_front() : 'x;
            `CHK({pslverr, prdata}, ea)
        end
        if (out_valid === 1'b1) begin
            er = rq.size() > 0 ? rq.pop_front() : 'x;
            `CHK({out_chan, out_value, ctl_valid, ctl_value}, er)
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int c = 0; c < 4; c++) begin
            rd(ba(c, RFM_R_CFG), 33'h000a0800);
            rd(ba(c, RFM_R_LIM), 33'h00000000);
            rd(ba(c, RFM_R_FSR), 33'h00ffffff);
            rd(ba(c, RFM_R_MMV), 33'h00000000);
            rd(ba(c, 3'h7), 33'h100000000);
        end
        rd(RFM_STS_OFS, 33'h00000000);
        rd(12'h0fc, 33'h100000000);
        rd(12'h042, 33'h100000000);
        done("reset values");
        for (int i = 0; i < 8; i++) rdg(0, int'(rnd() & 32'h000fffff), 65535);
        fe.idle();
        lines();
        done("raw path");
        foreach (tp[i]) begin
            wcfg(1, tp[i], 4'ha, 16'h0000, 20000, 1'b1, 2'h1);
            rdg(1, 100, 0);
            repeat (45) rdg(1, int'(32'd1100 + (rnd() & 32'h7)), 0);
            fe.idle();
        end
        done("filter points");
        wcfg(1, 7'h08, 4'h0, 16'h0000, 20000, 1'b1, 2'h2);
        rdg(1, 150, 0);
        rdg(1, 500, 0);
        rdg(1, 520, 0);
        fe.idle();
        rd(RFM_STS_OFS, {25'h0000000, sts});
        apb(1'b1, RFM_MSK_OFS, 32'h00000020);
        msk = 8'h20;
        lines();
        apb(1'b1, RFM_STS_OFS, 32'h00000020);
        sts[5] = 1'b0;
        lines();
        done("window restart");
        rd(ba(1, RFM_R_MAX), {9'h000, 24'(mx[1])});
        rd(ba(1, RFM_R_MIN), {9'h000, 24'(mn[1])});
        apb(1'b1, RFM_CTRL_OFS, 32'h00000001);
        mmv = '{default: 0};
        rd(ba(0, RFM_R_MMV), 33'h00000000);
        rdg(1, 300, 0);
        fe.idle();
        rd(ba(1, RFM_R_MAX), {9'h000, 24'(mx[1])});
        rd(ba(1, RFM_R_MIN), {9'h000, 24'(mn[1])});
        rd(ba(1, RFM_R_FLT), {9'h000, 24'(avg[1] / 256)});
        done("max min");
        wcfg(2, 7'h08, 4'ha, 16'h0064, 16777215, 1'b0, 2'h0);
        wcfg(3, 7'h08, 4'ha, 16'hffff, 16777215, 1'b0, 2'h0);
        rdg(2, 5, 100);
        rdg(3, 5, 29990);
        fe.idle();
        lines();
        rdg(3, 6, 29991);
        rdg(2, 6, 101);
        fe.idle();
        lines();
        apb(1'b1, RFM_MSK_OFS, 32'h0000000c);
        msk = 8'h0c;
        lines();
        apb(1'b1, RFM_STS_OFS, 32'h0000000c);
        sts[3:2] = 2'b00;
        lines();
        done("limit shutdown");
        results();
    end
endmodule // tb
bind rfm_reading_filter rfm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .rd_valid(rd_valid), .rd_chan(rd_chan), .rd_value(rd_value), .out_valid(out_valid),
    .out_chan(out_chan), .out_value(out_value), .ctl_valid(ctl_valid),
    .ctl_chan(ctl_chan), .ctl_value(ctl_value), .shutdown(shutdown));
